/* File: verilog/acfg_top.sv */
// Configuration registers, bank RAM and data-read command engine
// Summary of operation
// R01: Byte-wide register and RAM access; register/RAM copies move whole banks.
// R02: Configuration RAM of eight sixteen-byte banks, 128 bytes.
// R03: RAM uses one auto-incrementing pointer; bank end rolls to next bank.
// R04: Pointer past last byte of bank seven wraps to bank zero.
// R05: Upper address bits pick bank, lower four bits pick offset.
// R06: RAM is independent of live registers.
// R07: Setup bits 7-5 factory; bit 4 picks modulator divide 128 or 256.
// R08: Setup bit 3 reference enable, bit 2 reference level, bit 1 buffer.
// R09: Setup bit 0 flips output bit order inside a byte only.
// R10: Analog control resets 00h: burnout, two DAC ranges, gain.
// R11: Current DAC code registers reset to zero, set DAC level.
// R12: Direction bit 0 output, 1 input; all inputs after reset.
// R13: Eleven-bit decimation: low byte resets 80h, top three in mode.
// R14: Mode resets 07h; bit 7 read-only mirror of data ready.
// R15: Mode bit 6 unipolar, bits 5-4 filter select, bit 3 reserved.
// R16: Offset coefficient three bytes, low byte first, reset zero.
// R17: Full-scale coefficient low byte first, reset 24h 90h 67h.
// R18: Commands are one byte except register and RAM read/write; bytes back to back.
// R19: Host keeps chip select low for a whole command sequence.
// R20: Count field is transfers minus one; low nibble is start address.
// R21: Single read shifts 24 bits then raises data ready.
// R22: Continuous read presents each new result without new commands.
// R23: Continuous mode ends on stop or reset byte during result bytes.
// R24: Host sends stop between data ready falling and rising.
// R25: Data ready falls on new result, rises after read and before update.
// R26: Register read is 0001 rrrr then 0000 nnnn.
// R27: Register write is 0101 rrrr, count byte, then data.
`timescale 1ns/100ps

// ==========================================================
// Result FIFO
module acfg_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : acfg_fifo

// ==========================================================
// Top level
module acfg_top
	import acfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        sclk_pol,
	input  wire logic        din,
	output logic             dout,
	output logic             data_ready_n,
	input  wire logic        result_valid,
	output logic             result_ready,
	input  wire logic [23:0] result_data,
	output logic             mod_clk_en,
	output acfg_cfg_t        cfg
);

	// ==========================================================
	// Storage
	logic [7:0]      regs_reg [BANK_BYTES];
	logic [7:0]      ram_reg [RAM_BYTES];
	acfg_state_t     state_reg;
	logic [3:0]      addr_reg;
	logic [6:0]      ptr_reg;
	logic [6:0]      cnt_reg;
	logic [2:0]      bit_cnt_reg;
	logic [6:0]      rx_shift_reg;
	logic            act_q_reg;
	logic            dout_reg;
	logic            cont_reg;
	logic            fresh_reg;
	logic            upd_pend_reg;
	logic            data_ready_n_n_reg;
	logic [1:0]      res_idx_reg;
	logic [23:0]     out_word_reg;
	logic [7:0]      div_cnt_reg;

	// ==========================================================
	// Serial clock edges, both polarities
	logic       sclk_act;
	logic       lead;
	logic       trail;
	logic       byte_evt;
	logic [7:0] rx_byte;

	assign sclk_act = sclk_pol ? sclk : ~sclk;
	assign lead     = ~cs_n & sclk_act & ~act_q_reg;
	assign trail    = ~cs_n & ~sclk_act & act_q_reg;
	assign byte_evt = trail & (bit_cnt_reg == 3'd7);
	assign rx_byte  = {rx_shift_reg, din};

	// ==========================================================
	// Command decode
	logic [3:0] op;
	logic       in_idle;
	logic       res_phase;
	logic       cmd_register_read_cmd;
	logic       cmd_register_write_cmd;
	logic       cmd_ramr;
	logic       cmd_ramw;
	logic       cmd_to_ram;
	logic       cmd_to_reg;
	logic       cmd_reset;
	logic       cmd_stop;
	logic       cmd_one;
	logic       cmd_cont;

	assign op        = rx_byte[7:4];
	assign in_idle   = (state_reg == ST_IDLE);
	// Continuous mode owns the idle state while a fresh result waits
	assign res_phase = (state_reg == ST_RESULT) ||
	                   (in_idle && cont_reg && fresh_reg);   // [R22]
	assign cmd_register_read_cmd  = byte_evt & in_idle & ~cont_reg &
	                   (op == OP_REG_READ);                  // [R26]
	assign cmd_register_write_cmd  = byte_evt & in_idle & ~cont_reg &
	                   (op == OP_REG_WRITE);                 // [R27]
	assign cmd_ramr  = byte_evt & in_idle & ~cont_reg &
	                   (op == OP_RAM_READ) & ~rx_byte[3];
	assign cmd_ramw  = byte_evt & in_idle & ~cont_reg &
	                   (op == OP_RAM_WRITE) & ~rx_byte[3];
	assign cmd_to_ram = byte_evt & in_idle & ~cont_reg &
	                   (op == OP_REG_TO_RAM) & ~rx_byte[3];
	assign cmd_to_reg = byte_evt & in_idle & ~cont_reg &
	                   (op == OP_RAM_TO_REG) & ~rx_byte[3];
	assign cmd_one   = byte_evt & in_idle & ~cont_reg &
	                   (rx_byte == CMD_READ_ONE);
	assign cmd_cont  = byte_evt & in_idle & ~cont_reg &
	                   (rx_byte == CMD_CONT_READ);
	// Reset and stop are heard even mid-result in continuous mode
	assign cmd_reset = byte_evt & (in_idle || state_reg == ST_RESULT) &
	                   (rx_byte == CMD_RESET);               // [R23]
	assign cmd_stop  = byte_evt & cont_reg &
	                   (rx_byte == CMD_STOP_CONT);           // [R23]

	// ==========================================================
	// Register and RAM access strobes
	logic       reg_we;
	logic       ram_we;
	logic [2:0] bank_sel;
	logic [7:0] reg_rd;
	logic [7:0] ram_rd;
	logic [7:0] res_byte;
	logic [7:0] tx_byte;
	logic       tx_bit;

	assign reg_we   = byte_evt & (state_reg == ST_REGISTER_WRITE_CMD_DATA);   // [R01]
	assign ram_we   = byte_evt & (state_reg == ST_RAMW_DATA);   // [R01]
	assign bank_sel = rx_byte[2:0];

	// Offset doubles as register address inside a bank
	assign ram_rd   = ram_reg[ptr_reg];                         // [R05]
	assign reg_rd   = (addr_reg == REG_SETUP) ?
	                  {FACTORY_BITS, regs_reg[REG_SETUP][4:0]} :  // [R07]
	                  (addr_reg == REG_MODE) ?
	                  {data_ready_n_n_reg, regs_reg[REG_MODE][6:0]} :     // [R14]
	                  regs_reg[addr_reg];

	// Most significant byte leaves first
	assign res_byte = (res_idx_reg == 2'd0) ? out_word_reg[23:16] :
	                  (res_idx_reg == 2'd1) ? out_word_reg[15:8] :
	                  out_word_reg[7:0];                          // [R09]

	assign tx_byte  = (state_reg == ST_REGISTER_READ_CMD_DATA) ? reg_rd :
	                  (state_reg == ST_RAMR_DATA) ? ram_rd :
	                  res_phase ? res_byte : 8'h00;
	assign tx_bit   = cfg.lsb_first ? tx_byte[bit_cnt_reg] :
	                  tx_byte[3'd7 - bit_cnt_reg];                // [R09]

	// ==========================================================
	// Serial shifter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			act_q_reg    <= 1'b0;
			bit_cnt_reg  <= 3'd0;
			rx_shift_reg <= 7'h00;
			dout_reg     <= 1'b0;
		end else begin
			act_q_reg <= sclk_act;
			if (cs_n) begin
				bit_cnt_reg <= 3'd0;
			end else if (trail) begin
				// Input is always taken most significant bit first
				rx_shift_reg <= rx_byte[6:0];
				bit_cnt_reg  <= bit_cnt_reg + 3'd1;
			end
			if (lead) begin
				dout_reg <= tx_bit;
			end
		end
	end

	assign dout = dout_reg;

	// ==========================================================
	// Command state machine
	logic        last_xfer;
	acfg_state_t state_next;

	assign last_xfer = (cnt_reg == 7'd0);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cmd_register_read_cmd) begin
					state_next = ST_REGISTER_READ_CMD_CNT;
				end else if (cmd_register_write_cmd) begin
					state_next = ST_REGISTER_WRITE_CMD_CNT;
				end else if (cmd_ramr) begin
					state_next = ST_RAMR_CNT;
				end else if (cmd_ramw) begin
					state_next = ST_RAMW_CNT;
				end else if (cmd_one) begin
					state_next = ST_RESULT;                  // [R21]
				end
			end
			ST_REGISTER_READ_CMD_CNT: begin
				if (byte_evt) state_next = ST_REGISTER_READ_CMD_DATA;
			end
			ST_REGISTER_WRITE_CMD_CNT: begin
				if (byte_evt) state_next = ST_REGISTER_WRITE_CMD_DATA;
			end
			ST_RAMR_CNT: begin
				if (byte_evt) state_next = ST_RAMR_DATA;
			end
			ST_RAMW_CNT: begin
				if (byte_evt) state_next = ST_RAMW_DATA;
			end
			ST_REGISTER_READ_CMD_DATA, ST_REGISTER_WRITE_CMD_DATA,
			ST_RAMR_DATA, ST_RAMW_DATA: begin
				if (byte_evt && last_xfer) state_next = ST_IDLE;
			end
			ST_RESULT: begin
				if (cmd_reset ||
				    (byte_evt && res_idx_reg == 2'd2)) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// Dropping chip select abandons any sequence
		if (cs_n) begin
			state_next = ST_IDLE;                        // [R19]
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			addr_reg  <= 4'h0;
			ptr_reg   <= 7'h00;
			cnt_reg   <= 7'h00;
			cont_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (cmd_register_read_cmd || cmd_register_write_cmd) begin
				addr_reg <= rx_byte[3:0];                    // [R20]
			end else if (byte_evt && (state_reg == ST_REGISTER_READ_CMD_DATA ||
			                          state_reg == ST_REGISTER_WRITE_CMD_DATA)) begin
				// Register addresses wrap within the bank
				addr_reg <= addr_reg + 4'h1;
			end
			if (cmd_ramr || cmd_ramw) begin
				ptr_reg <= {bank_sel, 4'h0};
			end else if (byte_evt && (state_reg == ST_RAMR_DATA ||
			                          state_reg == ST_RAMW_DATA)) begin
				// Rolls into the next bank, bank seven back to zero
				ptr_reg <= ptr_reg + 7'h01;                  // [R03] [R04]
			end
			if (byte_evt && (state_reg == ST_REGISTER_READ_CMD_CNT ||
			                 state_reg == ST_REGISTER_WRITE_CMD_CNT)) begin
				cnt_reg <= {3'b000, rx_byte[3:0]};           // [R20]
			end else if (byte_evt && (state_reg == ST_RAMR_CNT ||
			                          state_reg == ST_RAMW_CNT)) begin
				cnt_reg <= rx_byte[6:0];
			end else if (byte_evt && !last_xfer) begin
				cnt_reg <= cnt_reg - 7'h01;
			end
			if (cmd_stop || cmd_reset) begin
				cont_reg <= 1'b0;                            // [R23]
			end else if (cmd_cont) begin
				cont_reg <= 1'b1;                            // [R22]
			end
		end
	end

	// ==========================================================
	// Live registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < BANK_BYTES; i++) begin
				regs_reg[i] <= REG_RESET[i];   // [R10] [R11] [R12] [R16] [R17]
			end
		end else if (cmd_reset) begin
			for (int i = 0; i < BANK_BYTES; i++) begin
				regs_reg[i] <= REG_RESET[i];
			end
		end else if (cmd_to_reg) begin
			// Whole bank replaces every register at once
			for (int i = 0; i < BANK_BYTES; i++) begin
				regs_reg[i] <= ram_reg[{bank_sel, 4'(i)}];   // [R01]
			end
		end else if (reg_we) begin
			regs_reg[addr_reg] <= rx_byte;                   // [R18]
		end
	end

	// ==========================================================
	// Bank RAM, separate from the live registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < RAM_BYTES; i++) begin
				ram_reg[i] <= 8'h00;                         // [R02]
			end
		end else if (cmd_to_ram) begin
			for (int i = 0; i < BANK_BYTES; i++) begin
				ram_reg[{bank_sel, 4'(i)}] <= regs_reg[i];   // [R01]
			end
		end else if (ram_we) begin
			ram_reg[ptr_reg] <= rx_byte;                     // [R06]
		end
	end

	// ==========================================================
	// Result path and data ready
	logic        busy_shift;
	logic        start_upd;
	logic        consumed;
	logic        fifo_valid;
	logic        fifo_ready;
	logic [23:0] fifo_data;

	// Hold off a word swap from a result byte's first trailing edge until its eighth
	assign busy_shift   = res_phase & (bit_cnt_reg != 3'd0);
	assign start_upd    = fifo_valid & ~busy_shift & ~upd_pend_reg;
	assign consumed     = byte_evt & res_phase & (res_idx_reg == 2'd2);
	assign fifo_ready   = upd_pend_reg;

	acfg_fifo #(
		.WIDTH (RESULT_BITS),
		.DEPTH (RESULT_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (result_valid),
		.in_ready  (result_ready),
		.in_data   (result_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_ready_n_n_reg   <= 1'b1;
			fresh_reg    <= 1'b0;
			upd_pend_reg <= 1'b0;
			res_idx_reg  <= 2'd0;
			out_word_reg <= 24'h00_0000;
		end else if (upd_pend_reg) begin
			out_word_reg <= fifo_data;
			data_ready_n_n_reg   <= 1'b0;                            // [R25]
			fresh_reg    <= 1'b1;
			upd_pend_reg <= 1'b0;
			res_idx_reg  <= 2'd0;
		end else if (start_upd) begin
			// High for one cycle ahead of the word changing
			data_ready_n_n_reg   <= 1'b1;                            // [R25]
			upd_pend_reg <= 1'b1;
		end else if (consumed) begin
			data_ready_n_n_reg  <= 1'b1;                             // [R21] [R25]
			fresh_reg   <= 1'b0;
			res_idx_reg <= 2'd0;
		end else if (cs_n) begin
			res_idx_reg <= 2'd0;
		end else if (byte_evt && res_phase) begin
			res_idx_reg <= res_idx_reg + 2'd1;
		end
	end

	assign data_ready_n = data_ready_n_n_reg;

	// ==========================================================
	// Modulator clock enable
	logic [7:0] div_last;

	assign div_last = regs_reg[REG_SETUP][SETUP_SPEED_BIT] ?
	                  8'(MOD_DIV_SLOW - 1) : 8'(MOD_DIV_FAST - 1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_reg <= 8'h00;
			mod_clk_en  <= 1'b0;
		end else begin
			mod_clk_en  <= (div_cnt_reg >= div_last);        // [R07]
			div_cnt_reg <= (div_cnt_reg >= div_last) ? 8'h00 :
			               div_cnt_reg + 8'h01;
		end
	end

	// ==========================================================
	// Configuration fields
	assign cfg.mod_clk_div256   = regs_reg[REG_SETUP][SETUP_SPEED_BIT];
	assign cfg.ref_enable = regs_reg[REG_SETUP][SETUP_REFEN_BIT]; // [R08]
	assign cfg.ref_level_select = regs_reg[REG_SETUP][SETUP_REFHI_BIT];
	assign cfg.buffer_enable    = regs_reg[REG_SETUP][SETUP_BUFEN_BIT];
	assign cfg.lsb_first        = regs_reg[REG_SETUP][SETUP_ORDER_BIT];
	assign cfg.burnout_source_enable = regs_reg[REG_ANALOG][7];  // [R10]
	assign cfg.current_dac_two_range = regs_reg[REG_ANALOG][6:5];
	assign cfg.current_dac_one_range = regs_reg[REG_ANALOG][4:3];
	assign cfg.gain_select      = regs_reg[REG_ANALOG][2:0];
	assign cfg.current_dac_one  = regs_reg[REG_IDAC_ONE];       // [R11]
	assign cfg.current_dac_two  = regs_reg[REG_IDAC_TWO];
	assign cfg.offset_trim_dac  = regs_reg[REG_OFS_TRIM];
	assign cfg.io_direction     = regs_reg[REG_IO_DIR];         // [R12]
	assign cfg.decimation_ratio = {regs_reg[REG_MODE][2:0],
	                               regs_reg[REG_DEC_LOW]};      // [R13]
	assign cfg.unipolar         = regs_reg[REG_MODE][MODE_UNIPOLAR_BIT];
	assign cfg.settling_filter_select = regs_reg[REG_MODE][5:4];  // [R15]
	assign cfg.offset_coeff     = {regs_reg[REG_OFS_LOW + 4'h2],
	                               regs_reg[REG_OFS_LOW + 4'h1],
	                               regs_reg[REG_OFS_LOW]};      // [R16]
	assign cfg.full_scale_coeff = {regs_reg[REG_FS_LOW + 4'h2],
	                               regs_reg[REG_FS_LOW + 4'h1],
	                               regs_reg[REG_FS_LOW]};       // [R17]

endmodule : acfg_top

/* File: verilog/acfg_pkg.sv */
// Package: constants and types for the converter configuration store
package acfg_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [3:0] REG_SETUP      = 4'h0;
	localparam logic [3:0] REG_ANALOG     = 4'h2;
	localparam logic [3:0] REG_IDAC_ONE   = 4'h3;
	localparam logic [3:0] REG_IDAC_TWO   = 4'h4;
	localparam logic [3:0] REG_OFS_TRIM   = 4'h5;
	localparam logic [3:0] REG_IO_DIR     = 4'h7;
	localparam logic [3:0] REG_DEC_LOW    = 4'h8;
	localparam logic [3:0] REG_MODE       = 4'h9;
	localparam logic [3:0] REG_OFS_LOW    = 4'ha;
	localparam logic [3:0] REG_FS_LOW     = 4'hd;

	// ==========================================================
	// Field positions
	localparam int SETUP_SPEED_BIT   = 4;
	localparam int SETUP_REFEN_BIT   = 3;
	localparam int SETUP_REFHI_BIT   = 2;
	localparam int SETUP_BUFEN_BIT   = 1;
	localparam int SETUP_ORDER_BIT   = 0;
	localparam int MODE_READY_BIT    = 7;
	localparam int MODE_UNIPOLAR_BIT = 6;

	// Factory bits of setup; value is arbitrary
	localparam logic [2:0] FACTORY_BITS = 3'h0;

	// ==========================================================
	// Reset values, one per register offset
	localparam logic [7:0] REG_RESET [16] = '{
		8'h0e, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
		8'h80, 8'h07, 8'h00, 8'h00, 8'h00, 8'h24, 8'h90, 8'h67
	};

	// ==========================================================
	// Command encodings
	localparam logic [3:0] OP_REG_READ   = 4'h1;
	localparam logic [3:0] OP_REG_WRITE  = 4'h5;
	localparam logic [3:0] OP_RAM_READ   = 4'h2;
	localparam logic [3:0] OP_RAM_WRITE  = 4'h6;
	localparam logic [3:0] OP_REG_TO_RAM = 4'h4;
	localparam logic [3:0] OP_RAM_TO_REG = 4'hc;
	localparam logic [7:0] CMD_READ_ONE  = 8'h01;
	localparam logic [7:0] CMD_CONT_READ = 8'h03;
	localparam logic [7:0] CMD_STOP_CONT = 8'h0f;
	localparam logic [7:0] CMD_RESET     = 8'hfe;

	// ==========================================================
	// Sizes and timing
	localparam int RAM_BANKS      = 8;
	localparam int BANK_BYTES     = 16;
	localparam int RAM_BYTES      = RAM_BANKS * BANK_BYTES;
	localparam int RESULT_BITS    = 24;
	localparam int RESULT_DEPTH   = 32;
	localparam int MOD_DIV_FAST   = 128;
	localparam int MOD_DIV_SLOW   = 256;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_REGISTER_READ_CMD_CNT  = 4'b0001,
		ST_REGISTER_READ_CMD_DATA = 4'b0011,
		ST_REGISTER_WRITE_CMD_CNT  = 4'b0010,
		ST_REGISTER_WRITE_CMD_DATA = 4'b0110,
		ST_RAMR_CNT  = 4'b0111,
		ST_RAMR_DATA = 4'b0101,
		ST_RAMW_CNT  = 4'b0100,
		ST_RAMW_DATA = 4'b1100,
		ST_RESULT    = 4'b1101
	} acfg_state_t;

	typedef struct packed {
		logic        mod_clk_div256;
		logic        ref_enable;
		logic        ref_level_select;
		logic        buffer_enable;
		logic        lsb_first;
		logic        burnout_source_enable;
		logic [1:0]  current_dac_two_range;
		logic [1:0]  current_dac_one_range;
		logic [2:0]  gain_select;
		logic [7:0]  current_dac_one;
		logic [7:0]  current_dac_two;
		logic [7:0]  offset_trim_dac;
		logic [7:0]  io_direction;
		logic [10:0] decimation_ratio;
		logic        unipolar;
		logic [1:0]  settling_filter_select;
		logic [23:0] offset_coeff;
		logic [23:0] full_scale_coeff;
	} acfg_cfg_t;

endpackage : acfg_pkg

/* File: tb/acfg_host_model.sv */
// Serial host model that drives the converter command link
`timescale 1ns/100ps
module acfg_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	// Three clocks a level keeps the two-clock minimum with margin
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			din  = tx[i];
			sclk = 1'b1;
			tick(3);
			rx[i] = dout;
			sclk  = 1'b0;
			tick(1);
			din = ~din; // Stale level would hide a late sample
			tick(2);
		end
	endtask : xfer
	task automatic begin_frame();
		cs_n = 1'b0;
		tick(2);
	endtask : begin_frame
	task automatic end_frame();
		cs_n = 1'b1;
		tick(3);
	endtask : end_frame
endmodule : acfg_host_model

/* File: tb/acfg_top_props.sv */
// Port-level checks for the configuration store
`timescale 1ns/100ps
module acfg_top_props
	import acfg_pkg::*;
(
	input wire logic      clk,
	input wire logic      rstn,
	input wire logic      cs_n,
	input wire logic      sclk,
	input wire logic      dout,
	input wire logic      data_ready_n,
	input wire logic      result_valid,
	input wire logic      result_ready,
	input wire logic      mod_clk_en,
	input wire acfg_cfg_t cfg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence quiet_s;
		(!mod_clk_en) [*8];
	endsequence
	reset_ports_a: assert property ($rose(rstn) |-> data_ready_n &&
		result_ready && !mod_clk_en && !dout) else $error("bad port reset");
	reset_cal_a: assert property ($rose(rstn) |-> cfg.offset_coeff == 0 &&
		cfg.full_scale_coeff == 24'h67_9024) else $error("bad coeff reset");
	reset_cfg_a: assert property ($rose(rstn) |-> cfg.io_direction == 8'hff
		&& cfg.decimation_ratio == 11'h780 && cfg.current_dac_one == 0)
		else $error("bad config reset");
	cfg_quiet_a: assert property ($changed(cfg) |-> !cs_n && !sclk)
		else $error("config moved outside a byte");
	dout_timing_a: assert property ($changed(dout) |-> sclk && $past(sclk))
		else $error("dout moved off the leading edge");
	mod_pulse_a: assert property (mod_clk_en |=> quiet_s)
		else $error("modulator strobe too long");
	mod_period_a: assert property (mod_clk_en && !cfg.mod_clk_div256
		|-> ##128 mod_clk_en) else $error("modulator period wrong");
	fifo_full_a: assert property ($fell(result_ready) |-> $past(result_valid))
		else $error("ready fell without a push");
endmodule : acfg_top_props

/* File: tb/test_acfg_top.sv */
// Self-checking bench for configuration store and result reads
`timescale 1ns/100ps
module test_acfg_top
	import acfg_pkg::*;
;
	localparam logic [7:0] DEF [16] = '{8'h0e, 8'h01, 0, 0, 0, 0, 0, 8'hff,
		8'h80, 8'h07, 0, 0, 0, 8'h24, 8'h90, 8'h67};
	logic        clk, rstn, cs_n, sclk, din, dout, data_ready_n;
	logic        result_valid, result_ready, mod_clk_en;
	logic [23:0] result_data;
	acfg_cfg_t   cfg;
	logic [31:0] seed = 32'h0000_cca7;
	logic [7:0]  regs [16];
	logic [7:0]  ram [128];
	logic [7:0]  stops [2] = '{CMD_STOP_CONT, CMD_RESET};
	logic [23:0] q [$];
	int          fails, comparisons;
	acfg_top i_acfg_top (.clk, .rstn, .cs_n, .sclk, .sclk_pol(1'b1), .din,
		.dout, .data_ready_n, .result_valid, .result_ready, .result_data,
		.mod_clk_en, .cfg);
	acfg_host_model i_acfg_host_model (.clk, .cs_n, .sclk, .din, .dout);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ==========================================================
	// Helpers and reference model
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [7:0] ord(input logic [7:0] b);
		return regs[0][0] ? {<<{b}} : b;
	endfunction : ord
	function automatic logic [7:0] rd_exp(input int a);
		if (a == 0) return {FACTORY_BITS, regs[0][4:0]};
		if (a == 9) return {1'b1, regs[9][6:0]};
		return regs[a];
	endfunction : rd_exp
	function automatic acfg_cfg_t cfg_exp();
		return {regs[0][4:0], regs[2], regs[3], regs[4], regs[5], regs[7],
			regs[9][2:0], regs[8], regs[9][6:4], regs[12], regs[11],
			regs[10], regs[15], regs[14], regs[13]};
	endfunction : cfg_exp
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic check(input string nm, input logic [127:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic results();
		if (fails == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task automatic send(input logic [7:0] b);
		logic [7:0] rx;
		i_acfg_host_model.xfer(b, rx);
	endtask : send
	// Register and bank memory access; op bit 1 is RAM, bit 2 is write
	task automatic xact(input logic [3:0] op, a, input int n);
		logic [7:0] rx, d;
		int ix;
		i_acfg_host_model.begin_frame();
		send({op, a});
		send(8'(n - 1));
		for (int k = 0; k < n; k++) begin
			ix = op[1] ? (a * 16 + k) % 128 : (a + k) % 16;
			d = 8'(rnd());
			if (!op[1]) d &= (ix == 0) ? 8'hef : (ix == 9) ? 8'hf7 : 8'hff;
			if (op[2] && op[1]) ram[ix] = d;
			if (op[2] && !op[1]) regs[ix] = d;
			i_acfg_host_model.xfer(op[2] ? d : 8'h00, rx);
			if (!op[2]) check("rd", ord(rx), op[1] ? ram[ix] : rd_exp(ix));
		end
		i_acfg_host_model.end_frame();
	endtask : xact
	task automatic push(input logic [23:0] v);
		result_data  = v;
		result_valid = 1'b1;
		// Output word carries the newest result once the backlog has drained
		q.delete();
		q.push_back(v);
		tick(1);
	endtask : push
	task automatic read_result(input logic cont, input logic [7:0] last);
		logic [23:0] exp;
		logic [7:0] rx;
		for (int n = 0; n < 300 && data_ready_n !== 1'b0; n++) tick(1);
		check("ready_n", data_ready_n, 0);
		exp = q.pop_front();
		if (!cont) i_acfg_host_model.begin_frame();
		if (!cont) send(CMD_READ_ONE);
		for (int b = 2; b >= 0; b--) begin
			i_acfg_host_model.xfer(b == 0 ? last : 8'h00, rx);
			check("result", ord(rx), exp[b * 8 +: 8]);
		end
		if (!cont) i_acfg_host_model.end_frame();
		if (q.size() == 0) check("done", data_ready_n, 1);
	endtask : read_result
	// ==========================================================
	// Scenarios
	initial begin
		rstn = 1'b0;
		result_valid = 1'b0;
		result_data = 24'h00_0000;
		regs = DEF;
		repeat (20) @(posedge clk);
		#1 rstn = 1'b1;
		xact(OP_REG_READ, 4'h0, 16);
		check("cfg", cfg, cfg_exp());
		xact(OP_REG_WRITE, 4'he, 3);
		xact(OP_REG_WRITE, 4'h2, 11);
		check("cfg", cfg, cfg_exp());
		xact(OP_REG_READ, 4'h5, 16);
		xact(OP_RAM_WRITE, 4'h7, 18);
		xact(OP_RAM_READ, 4'h0, 2);
		xact(OP_RAM_READ, 4'h7, 16);
		xact(OP_REG_READ, 4'h0, 16);
		for (int n = 0; n < 100 && result_ready === 1'b1; n++)
			push(24'(rnd()));
		result_valid = 1'b0;
		check("full", result_ready, 0);
		// Backlog falls through two cycles a word to the newest
		tick(80);
		while (q.size() > 0) read_result(1'b0, 8'h00);
		check("drained", result_ready, 1);
		foreach (stops[i]) begin
			i_acfg_host_model.begin_frame();
			send(CMD_CONT_READ);
			push(24'(rnd()));
			result_valid = 1'b0;
			read_result(1'b1, stops[i]);
			i_acfg_host_model.end_frame();
			if (stops[i] == CMD_RESET) regs = DEF;
			xact(OP_REG_READ, 4'h0, 16);
		end
		results();
	end
	initial begin
		#4_000_000;
		fails++;
		results();
	end
endmodule : test_acfg_top
bind acfg_top acfg_top_props i_acfg_top_props (.clk, .rstn, .cs_n, .sclk,
	.dout, .data_ready_n, .result_valid, .result_ready, .mod_clk_en, .cfg);
